// ==== hdl/rom_pkg.sv ====
// Purpose: Constants for the regenerative overload monitor
// Assumes: 100 MHz core clock, APB register access, 16-bit parameters
// Notes: Register indices map to byte address index*4
package rom_pkg;
    // Register indices
    localparam logic [15:0] IDX_SELECT = 16'h2009;
    localparam logic [15:0] IDX_DERATE = 16'h200a;
    localparam logic [15:0] IDX_RESIST = 16'h200b;
    localparam logic [15:0] IDX_POWER = 16'h200c;
    localparam logic [15:0] IDX_PEAK = 16'h200d;
    localparam logic [15:0] IDX_DURATION = 16'h200e;
    localparam logic [15:0] IDX_STATUS = 16'h2010;
    localparam logic [15:0] IDX_MASK = 16'h2011;
    localparam logic [15:0] IDX_RATE = 16'h2012;

    // Reset values
    localparam logic [15:0] SELECT_RST = 16'h0001;
    localparam logic [15:0] DERATE_RST = 16'h0064;
    localparam logic [15:0] RESIST_RST = 16'h0000;
    localparam logic [15:0] POWER_RST = 16'h0000;
    localparam logic [15:0] PEAK_RST = 16'h0000;
    localparam logic [15:0] DURATION_RST = 16'h0000;
    localparam logic [1:0] MASK_RST = 2'h0;

    // Selection code for a resistor outside the drive
    localparam logic [15:0] SEL_EXTERNAL = 16'h0001;

    // Status bit positions
    localparam int ST_TRIP = 0;
    localparam int ST_REGEN = 1;
    localparam int STAT_W = 2;

    // Regeneration activation voltage and derived square
    localparam int REGEN_VOLT_V = 385;
    localparam logic [15:0] REGEN_VOLT = 16'(REGEN_VOLT_V);
    localparam logic [17:0] REGEN_VOLT_SQ = 18'(REGEN_VOLT_V * REGEN_VOLT_V);
    localparam int DIV_STEPS = 18;

    // Percent scaling of the derating factor
    localparam logic [55:0] PERCENT_SCALE = 56'h64;

    // Energy integration period
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_ALARM = 3'b100
    } rom_state_t;
endpackage

// ==== hdl/rom_divider.sv ====
// Purpose: Restoring divider for the consumption rate
// Assumes: Divisor nonzero when started
// Notes: One quotient bit per clock, done pulses when finished
module rom_divider (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [17:0] dividend,
    input wire logic [15:0] divisor,
    output logic [17:0] quotient,
    output logic done
);
    logic [16:0] rem;
    logic [16:0] next_rem;
    logic [17:0] next_quotient;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic busy;
    logic next_busy;
    logic next_done;
    logic [16:0] shifted;

    // Next step of the division
    always_comb begin
        next_rem = rem;
        next_quotient = quotient;
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        shifted = {rem[15:0], quotient[17]};
        if (start) begin
            next_rem = 17'h0;
            next_quotient = dividend;
            next_cnt = 5'(rom_pkg::DIV_STEPS);
            next_busy = 1'b1;
        end else if (busy) begin
            if (shifted >= {1'b0, divisor}) begin
                next_rem = shifted - {1'b0, divisor};
                next_quotient = {quotient[16:0], 1'b1};
            end else begin
                next_rem = shifted;
                next_quotient = {quotient[16:0], 1'b0};
            end
            next_cnt = cnt - 5'h1;
            if (cnt == 5'h1) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    // Divider state
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rem <= 17'h0;
            quotient <= 18'h0;
            cnt <= 5'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            rem <= next_rem;
            quotient <= next_quotient;
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule

// ==== hdl/rom_monitor.sv ====
// Purpose: Regenerative braking overload monitor with APB registers
// Assumes: dcLinkVoltage is a 16-bit reading in volts from another domain
// Notes: Energy kept in watt-milliseconds, energy times 100 compared against budget
//
// The APB interface to the registers is this design's own decision.
module rom_monitor #(
    parameter int MS_TICK_CYCLES = rom_pkg::MS_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] dcLinkVoltage,
    output logic regenOverloadAlarm,
    output logic regenActive,
    output logic irq
);
    // Byte address of a register index
    function automatic logic [15:0] regAddr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

    // Whether a byte address hits a register
    function automatic logic isMapped(input logic [15:0] addr);
        return addr == regAddr(rom_pkg::IDX_SELECT) || addr == regAddr(rom_pkg::IDX_DERATE)
            || addr == regAddr(rom_pkg::IDX_RESIST) || addr == regAddr(rom_pkg::IDX_POWER)
            || addr == regAddr(rom_pkg::IDX_PEAK) || addr == regAddr(rom_pkg::IDX_DURATION)
            || addr == regAddr(rom_pkg::IDX_STATUS) || addr == regAddr(rom_pkg::IDX_MASK)
            || addr == regAddr(rom_pkg::IDX_RATE);
    endfunction

    logic [15:0] resistorSel, derate, resistance, power, peak, duration;
    logic [15:0] next_resistorSel, next_derate, next_resistance, next_power;
    logic [15:0] next_peak, next_duration;
    logic [rom_pkg::STAT_W-1:0] status, mask, next_status, next_mask, statusSet;
    logic [31:0] next_prdata;
    logic [17:0] rate, next_rate, divQuotient;
    logic rateValid, next_rateValid, divStart, divDone;
    logic [15:0] voltS1, voltS2, voltS3, voltStable, next_voltStable;
    logic next_regenActive;
    rom_pkg::rom_state_t state, next_state;
    logic [47:0] energy, next_energy, budget;
    logic [16:0] tickCnt, next_tickCnt;
    logic msTick, overBudget, monitorOn;
    logic wrEn, rdEn, setupEn;

    // Zero-wait slave, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && !isMapped(paddr);
    assign setupEn = psel && !penable;
    assign wrEn = psel && penable && pwrite && isMapped(paddr);
    assign rdEn = psel && penable && !pwrite;

    // Register writes and read data capture
    always_comb begin
        next_resistorSel = resistorSel;
        next_derate = derate;
        next_resistance = resistance;
        next_power = power;
        next_peak = peak;
        next_duration = duration;
        next_mask = mask;
        next_prdata = prdata;
        divStart = 1'b0;
        if (wrEn) begin
            unique case (paddr)
                regAddr(rom_pkg::IDX_SELECT): next_resistorSel = pwdata[15:0];
                regAddr(rom_pkg::IDX_DERATE): next_derate = pwdata[15:0];
                regAddr(rom_pkg::IDX_RESIST): begin
                    next_resistance = pwdata[15:0];
                    divStart = pwdata[15:0] != 16'h0;
                end
                regAddr(rom_pkg::IDX_POWER): next_power = pwdata[15:0];
                regAddr(rom_pkg::IDX_PEAK): next_peak = pwdata[15:0];
                regAddr(rom_pkg::IDX_DURATION): next_duration = pwdata[15:0];
                regAddr(rom_pkg::IDX_MASK): next_mask = pwdata[rom_pkg::STAT_W-1:0];
                default: ;
            endcase
        end
        if (setupEn) begin
            next_prdata = 32'h0;
            unique case (paddr)
                regAddr(rom_pkg::IDX_SELECT): next_prdata[15:0] = resistorSel;
                regAddr(rom_pkg::IDX_DERATE): next_prdata[15:0] = derate;
                regAddr(rom_pkg::IDX_RESIST): next_prdata[15:0] = resistance;
                regAddr(rom_pkg::IDX_POWER): next_prdata[15:0] = power;
                regAddr(rom_pkg::IDX_PEAK): next_prdata[15:0] = peak;
                regAddr(rom_pkg::IDX_DURATION): next_prdata[15:0] = duration;
                regAddr(rom_pkg::IDX_STATUS): next_prdata[rom_pkg::STAT_W-1:0] = status;
                regAddr(rom_pkg::IDX_MASK): next_prdata[rom_pkg::STAT_W-1:0] = mask;
                regAddr(rom_pkg::IDX_RATE): next_prdata = {rateValid, 13'h0, rate};
                default: ;
            endcase
        end
    end

    // Sticky events; read clears only bits that were returned
    always_comb begin
        next_status = status | statusSet;
        if (rdEn && paddr == regAddr(rom_pkg::IDX_STATUS)) begin
            next_status = (status & ~prdata[rom_pkg::STAT_W-1:0]) | statusSet;
        end
    end

    // One level interrupt from unmasked status
    assign irq = |(status & mask);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            resistorSel <= rom_pkg::SELECT_RST;
            derate <= rom_pkg::DERATE_RST;
            resistance <= rom_pkg::RESIST_RST;
            power <= rom_pkg::POWER_RST;
            peak <= rom_pkg::PEAK_RST;
            duration <= rom_pkg::DURATION_RST;
            mask <= rom_pkg::MASK_RST;
            status <= '0;
            prdata <= 32'h0;
        end else begin
            resistorSel <= next_resistorSel;
            derate <= next_derate;
            resistance <= next_resistance;
            power <= next_power;
            peak <= next_peak;
            duration <= next_duration;
            mask <= next_mask;
            status <= next_status;
            prdata <= next_prdata;
        end
    end

    // rate from squared voltage over ohms
    rom_divider u_rom_divider (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(divStart),
        .dividend(rom_pkg::REGEN_VOLT_SQ),
        .divisor(next_resistance),
        .quotient(divQuotient),
        .done(divDone)
    );

    // Rate capture, invalid while a new value divides
    always_comb begin
        next_rate = rate;
        next_rateValid = rateValid;
        if (wrEn && paddr == regAddr(rom_pkg::IDX_RESIST)) begin
            next_rateValid = 1'b0;
        end else if (divDone) begin
            next_rate = divQuotient;
            next_rateValid = 1'b1;
        end
    end

    // Voltage accepted once second and third stage agree
    always_comb begin
        next_voltStable = voltStable;
        if (voltS2 == voltS3) begin
            next_voltStable = voltS3;
        end
        next_regenActive = next_voltStable >= rom_pkg::REGEN_VOLT;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rate <= 18'h0;
            rateValid <= 1'b0;
            voltS1 <= 16'h0;
            voltS2 <= 16'h0;
            voltS3 <= 16'h0;
            voltStable <= 16'h0;
            regenActive <= 1'b0;
        end else begin
            rate <= next_rate;
            rateValid <= next_rateValid;
            voltS1 <= dcLinkVoltage;
            voltS2 <= voltS1;
            voltS3 <= voltS2;
            voltStable <= next_voltStable;
            regenActive <= next_regenActive;
        end
    end

    assign budget = 48'(peak) * 48'(derate) * 48'(duration);
    assign overBudget = 56'(energy) * rom_pkg::PERCENT_SCALE > 56'(budget);
    assign monitorOn = resistorSel == rom_pkg::SEL_EXTERNAL && rateValid;
    assign msTick = tickCnt == 17'(MS_TICK_CYCLES - 1);
    assign regenOverloadAlarm = state == rom_pkg::ST_ALARM;

    // Episode sequencing and energy integration
    always_comb begin
        next_state = state;
        next_energy = energy;
        next_tickCnt = 17'h0;
        statusSet = '0;
        unique case (state)
            rom_pkg::ST_IDLE: begin
                next_energy = 48'h0;
                if (regenActive && monitorOn) begin
                    next_state = rom_pkg::ST_ACTIVE;
                    statusSet[rom_pkg::ST_REGEN] = 1'b1;
                end
            end
            rom_pkg::ST_ACTIVE: begin
                if (!regenActive || !monitorOn) begin
                    next_state = rom_pkg::ST_IDLE;
                    next_energy = 48'h0;
                end else if (overBudget) begin
                    next_state = rom_pkg::ST_ALARM;
                    statusSet[rom_pkg::ST_TRIP] = 1'b1;
                end else begin
                    next_tickCnt = msTick ? 17'h0 : tickCnt + 17'h1;
                    if (msTick) begin
                        next_energy = energy + 48'(rate);
                    end
                end
            end
            rom_pkg::ST_ALARM: begin
                if (!regenActive || !monitorOn) begin
                    next_state = rom_pkg::ST_IDLE;
                    next_energy = 48'h0;
                end
            end
            default: begin
                next_state = rom_pkg::ST_IDLE;
                next_energy = 48'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= rom_pkg::ST_IDLE;
            energy <= 48'h0;
            tickCnt <= 17'h0;
        end else begin
            state <= next_state;
            energy <= next_energy;
            tickCnt <= next_tickCnt;
        end
    end

    // Helper flag for the first cycle after reset
    logic seenClock;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seenClock <= 1'b0;
        end else begin
            seenClock <= 1'b1;
        end
    end

    sel_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !seenClock |-> resistorSel == 16'h0001 && resistance == 16'h0 && power == 16'h0)
        else $error("parameter reset values wrong");

    regen_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        energy > $past(energy) |-> $past(regenActive) && $past(state) == rom_pkg::ST_ACTIVE)
        else $error("energy grew outside regeneration");

    rate_calc_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        rateValid |-> 34'(rate) * 34'(resistance) <= 34'(rom_pkg::REGEN_VOLT_SQ)
            && 34'(rate + 18'h1) * 34'(resistance) > 34'(rom_pkg::REGEN_VOLT_SQ))
        else $error("consumption rate wrong");

    alarm_cause_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(regenOverloadAlarm) |-> $past(overBudget) && $past(regenActive))
        else $error("alarm without budget exceeded");

    alarm_trip_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        state == rom_pkg::ST_ACTIVE && regenActive && monitorOn && overBudget
            |=> regenOverloadAlarm ##1 status[rom_pkg::ST_TRIP] || regenOverloadAlarm)
        else $error("budget exceeded without alarm");

    energy_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        state != rom_pkg::ST_IDLE && !regenActive |=> energy == 48'h0 && !regenOverloadAlarm)
        else $error("energy not cleared at episode end");

    tick_step_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        state == rom_pkg::ST_ACTIVE && regenActive && monitorOn && !overBudget && msTick
            |=> energy == $past(energy) + 48'($past(rate)))
        else $error("energy step differs from rate");

    trip_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(regenOverloadAlarm) |-> status[rom_pkg::ST_TRIP] && (mask[rom_pkg::ST_TRIP] == irq
            || status[rom_pkg::ST_REGEN]))
        else $error("trip not recorded in status");
endmodule

// ==== test/rom_brake_link.sv ====
// Purpose: DC link model with an external braking resistor fitted
// Assumes: The bench says when the motor feeds energy back
// Notes: Link rests at a nominal level outside regeneration
module rom_brake_link #(
    parameter logic [15:0] IDLE_V = 16'h0136
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic regenOn,
    input wire logic [15:0] peakVolt,
    output logic [15:0] dcLinkVoltage
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dcLinkVoltage <= IDLE_V;
        end else begin
            dcLinkVoltage <= regenOn ? peakVolt : IDLE_V; // Pumped up while braking
        end
    end
endmodule

// ==== test/regen_overload_monitor_test.sv ====
// Purpose: Self-checking bench for the regenerative overload monitor
// Assumes: Energy tick shortened to 10 cycles, 30 ohm 300 W resistor
// Notes: Trip times checked from one tick below the computed count to one tick plus 12 cycles above it
module regen_overload_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    localparam longint RATE = (385 * 385) / 30;
    logic coreClk = 1'b0;
    logic arstN = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, alarm, regenActive, irq;
    logic regenOn = 1'b0;
    logic [15:0] peakVolt = 16'h0181;
    logic [15:0] dcLinkVoltage;
    int mismatches = 0;
    int nChecks = 0;

    always #5 coreClk = ~coreClk;

    rom_monitor #(.MS_TICK_CYCLES(TICK)) u_rom_monitor (
        .core_clk(coreClk), .arst_n(arstN), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dcLinkVoltage(dcLinkVoltage),
        .regenOverloadAlarm(alarm), .regenActive(regenActive), .irq(irq)
    );

    rom_brake_link u_rom_brake_link (
        .core_clk(coreClk), .arst_n(arstN), .regenOn(regenOn),
        .peakVolt(peakVolt), .dcLinkVoltage(dcLinkVoltage)
    );

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Single place where the run ends
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge coreClk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= wd;
        @(posedge coreClk);
        penable <= 1'b1;
        do begin
            @(posedge coreClk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(idx, 1'b1, d, rd, err);
    endtask

    task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(idx, 1'b0, 32'h0, rd, err);
        check(what, rd, exp);
    endtask

    // Energy ticks needed to pass the budget for a derating value
    function automatic longint ticks_to_trip(input longint derate);
        return (longint'(1500) * derate * 5000) / (RATE * 100) + 1;
    endfunction

    // Start regeneration and time the alarm from that moment
    task automatic trip_time(input longint n);
        int cyc;
        cyc = 0;
        regenOn <= 1'b1;
        while (alarm !== 1'b1 && cyc < 40000) begin
            @(posedge coreClk);
            cyc++;
        end
        if (alarm !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
        check("trip window", 32'(cyc >= (n - 1) * TICK && cyc <= (n + 1) * TICK + 12), 1);
    endtask

    task automatic test_regs();
        logic [31:0] rd;
        logic err;
        rdchk("select reset", rom_pkg::IDX_SELECT, 32'h1);
        rdchk("resistance reset", rom_pkg::IDX_RESIST, 32'h0);
        rdchk("power reset", rom_pkg::IDX_POWER, 32'h0);
        apb(16'h2020, 1'b0, 32'h0, rd, err);
        check("unmapped error", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test_regs done");
    endtask

    task automatic test_config();
        // Programming order: select, resistance, power, then peak with duration
        wr(rom_pkg::IDX_SELECT, 32'h1);
        rdchk("select value", rom_pkg::IDX_SELECT, 32'h1);
        wr(rom_pkg::IDX_RESIST, 32'd30);
        wr(rom_pkg::IDX_POWER, 32'd300);
        wr(rom_pkg::IDX_PEAK, 32'd1500);
        wr(rom_pkg::IDX_DURATION, 32'd5000);
        rdchk("resistance value", rom_pkg::IDX_RESIST, 32'd30);
        rdchk("power value", rom_pkg::IDX_POWER, 32'd300);
        repeat (30) @(posedge coreClk);
        rdchk("rate", rom_pkg::IDX_RATE, {1'b1, 13'h0, 18'(RATE)});
        $display("test_config done");
    endtask

    task automatic test_threshold();
        peakVolt <= 16'd384;
        regenOn <= 1'b1;
        repeat (12) @(posedge coreClk);
        check("below level", 32'(regenActive), 32'h0);
        peakVolt <= 16'd385;
        repeat (12) @(posedge coreClk);
        check("at level", 32'(regenActive), 32'h1);
        regenOn <= 1'b0;
        repeat (12) @(posedge coreClk);
        check("after stop", 32'(regenActive), 32'h0);
        $display("test_threshold done");
    endtask

    task automatic test_trip_full();
        trip_time(ticks_to_trip(100));
        check("masked irq", 32'(irq), 32'h0);
        regenOn <= 1'b0;
        repeat (12) @(posedge coreClk);
        check("alarm cleared", 32'(alarm), 32'h0);
        wr(rom_pkg::IDX_DERATE, 32'd50);
        wr(rom_pkg::IDX_MASK, 32'h1);
        rdchk("status clear", rom_pkg::IDX_STATUS, 32'h3);
        $display("test_trip_full done");
    endtask

    task automatic test_derate_irq();
        logic [31:0] rd;
        logic err;
        trip_time(ticks_to_trip(50));
        check("irq raised", 32'(irq), 32'h1);
        apb(rom_pkg::IDX_STATUS, 1'b0, 32'h0, rd, err);
        check("trip flag", rd & 32'h1, 32'h1);
        apb(rom_pkg::IDX_STATUS, 1'b0, 32'h0, rd, err);
        check("trip flag cleared", rd & 32'h1, 32'h0);
        check("irq cleared", 32'(irq), 32'h0);
        regenOn <= 1'b0;
        repeat (12) @(posedge coreClk);
        $display("test_derate_irq done");
    endtask

    // Selection other than external: no episode may start
    task automatic test_select_off();
        wr(rom_pkg::IDX_SELECT, 32'h0);
        regenOn <= 1'b1;
        repeat (40) @(posedge coreClk);
        check("regen seen", 32'(regenActive), 32'h1);
        check("no episode alarm", 32'(alarm), 32'h0);
        rdchk("no start flag", rom_pkg::IDX_STATUS, 32'h0);
        regenOn <= 1'b0;
        repeat (12) @(posedge coreClk);
        wr(rom_pkg::IDX_SELECT, 32'h1);
        rdchk("select restored", rom_pkg::IDX_SELECT, 32'h1);
        $display("test_select_off done");
    endtask

    task automatic test_episode();
        regenOn <= 1'b1;
        repeat (int'(ticks_to_trip(50) / 2) * TICK) @(posedge coreClk);
        regenOn <= 1'b0;
        repeat (12) @(posedge coreClk);
        check("no early trip", 32'(alarm), 32'h0);
        trip_time(ticks_to_trip(50));
        regenOn <= 1'b0;
        repeat (12) @(posedge coreClk);
        $display("test_episode done");
    endtask

    initial begin
        repeat (20) @(posedge coreClk);
        arstN <= 1'b1;
        test_regs();
        test_config();
        test_threshold();
        test_trip_full();
        test_derate_irq();
        test_select_off();
        test_episode();
        tally_and_finish();
    end
endmodule
